// [verilog/atc_defines.svh]
// offsets, field positions, reset values and timing counts of the trigger block
// assumes inclusion by bare name
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

`define ATC_OFF_CTRL      8'h00
`define ATC_OFF_CMD       8'h04
`define ATC_OFF_START     8'h08
`define ATC_OFF_REF       8'h0C
`define ATC_OFF_PAUSE     8'h10
`define ATC_OFF_COUNT     8'h14
`define ATC_OFF_PRETRIG   8'h18
`define ATC_OFF_DELAY     8'h1C
`define ATC_OFF_PERIOD    8'h20
`define ATC_OFF_TSTART    8'h24
`define ATC_OFF_TSYNC     8'h28
`define ATC_OFF_STATUS    8'h2C
`define ATC_OFF_SAMPLES   8'h30
`define ATC_OFF_WRPTR     8'h34
`define ATC_OFF_TIME      8'h38

// ctrl fields
`define ATC_CTRL_CONT     0
`define ATC_CTRL_REFEN    1
`define ATC_CTRL_SYNCEN   2
`define ATC_CTRL_SYNCSHR  3
// cmd fields (write one to act)
`define ATC_CMD_START     0
`define ATC_CMD_STOP      1
`define ATC_CMD_SYNC      2
// trigger config fields: source[3:0], kind[5:4], polarity bit 8
`define ATC_TRIG_POL      8
`define ATC_TRIG_EN       9

`define ATC_RESP_OKAY     2'b00
`define ATC_RESP_SLVERR   2'b10
`define ATC_DEF_PERIOD    32'h0000_0031
`define ATC_SYNC_NS       100
`define ATC_CLK_NS        20
`define ATC_SYNC_CYC      ((`ATC_SYNC_NS + `ATC_CLK_NS - 1) / `ATC_CLK_NS)
`define ATC_SYNC_CYC_W    8

`endif

// [verilog/atc_pkg.sv]
// types shared by the acquisition trigger block
// assumes the defines header is on the include path
package atc_pkg;
    typedef enum logic [1:0] {SRC_TERMINAL, SRC_COUNTER, SRC_ANALOG, SRC_TIME} atc_src_kind_t;

    typedef enum {ST_IDLE, ST_DELAY, ST_PRE, ST_ARMED, ST_POST, ST_RUN} atc_state_t;

    typedef struct packed {
        logic          enable;
        logic          polarity;
        atc_src_kind_t kind;
        logic [3:0]    source;
    } atc_trig_cfg_t;

    typedef struct packed {
        logic startPulse;
        logic refPulse;
        logic sampleClock;
        logic syncPulse;
    } atc_events_t;
endpackage

// [verilog/atc_trigger_ctrl.sv]
// acquisition trigger control: start, reference and pause triggers, sample gating and sync pulse
// assumes an AXI4-Lite master on mclk; only terminal inputs are asynchronous
// Overview of operation
// - start without configured trigger begins acquisition on software start command
// - digital start from selected terminal or counter output on chosen edge
// - finite mode without reference stops after configured sample count
// - continuous mode runs until software stop command
// - no samples are taken before the start trigger event
// - programmable delay from start trigger to first internal sample
// - analog comparison start begins on first rising edge of event
// - time start fires when time reference reaches programmed value
// - start trigger drives terminal outputs as active-high pulse
// - posttrigger count equals buffer size minus pretrigger count
// - reference detection armed only after pretrigger samples captured
// - full buffer overwrites oldest sample while waiting for reference
// - after reference keep storing until posttrigger count, then end
// - digital reference from selected terminal or internal signal, chosen edge
// - analog comparison reference stops on configured rising or falling edge
// - reference trigger routable to terminal outputs, active high
// - pause trigger active level holds sample clock; inactive resumes
// - pause active level programmable high or low, selectable source
// - analog comparison pause uses event level per configured polarity
// - pause responds to level only, edges have no separate effect
// - sync pulse to oversampling modules at programmed time value
// - unshared sync pulse issued by software even with time start
// - each sample clock pulse starts one sample of all channels
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "atc_defines.svh"

module atc_trigger_ctrl
    import atc_pkg::*;
#(
    parameter int NUM_TERM  = 8,
    parameter int NUM_CNT   = 4,
    parameter int BUF_DEPTH = 1024
)
(
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      srst,
    // axi4-lite write address and data
    input  wire logic [7:0]                awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    // axi4-lite read
    input  wire logic [7:0]                araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    // trigger sources
    input  wire logic [NUM_TERM-1:0]       programmable_function_terminal_in,
    input  wire logic [NUM_CNT-1:0]        counterOut,
    input  wire logic                      analogCompEvent,
    input  wire logic [31:0]               timeRef,
    // timing outputs
    output logic [NUM_TERM-1:0]            programmable_function_terminal_out,
    output atc_events_t                    events,
    output logic [$clog2(BUF_DEPTH)-1:0]   sampleAddr,
    output logic                           acqActive
);
    localparam int AW = $clog2(BUF_DEPTH);

    // configuration registers
    logic [3:0]    ctrl_q;
    atc_trig_cfg_t startCfg_q, refCfg_q, pauseCfg_q;
    logic [31:0]   count_q, pretrig_q, delay_q, period_q, tStart_q, tSync_q;
    logic [NUM_TERM-1:0] routeStart_q, routeRef_q;

    // run state
    atc_state_t    state_q;
    logic [31:0]   sampCnt_q, phaseCnt_q, divCnt_q;
    logic [AW-1:0] wrPtr_q;
    logic          wrapped_q, done_q, refSeen_q;
    logic [`ATC_SYNC_CYC_W-1:0] syncCnt_q;
    logic          tSyncFired_q;

    // two-stage synchronisers on external terminals, then one delay stage for edges
    logic [NUM_TERM-1:0] termMeta_q, termSync_q;
    logic [NUM_CNT-1:0]  cntPrev_q;
    logic                acePrev_q, aceQual_q;

    logic [NUM_TERM-1:0] termPrev_q;
    always_ff @(posedge mclk)
    begin
        termMeta_q <= programmable_function_terminal_in;
        termSync_q <= termMeta_q;
        termPrev_q <= termSync_q;
        cntPrev_q  <= counterOut;
        acePrev_q  <= aceQual_q;
        aceQual_q  <= analogCompEvent;
    end

    // source selection: level now and one cycle ago
    function automatic logic [1:0] pick(input atc_trig_cfg_t c,
                                        input logic [NUM_TERM-1:0] tn, input logic [NUM_TERM-1:0] tp,
                                        input logic [NUM_CNT-1:0] cn, input logic [NUM_CNT-1:0] cp,
                                        input logic an, input logic ap);
        logic [1:0] r;
        r = 2'b00;
        unique case (c.kind)
            SRC_TERMINAL: r = {tn[c.source % NUM_TERM], tp[c.source % NUM_TERM]};
            SRC_COUNTER:  r = {cn[c.source % NUM_CNT], cp[c.source % NUM_CNT]};
            SRC_ANALOG:   r = {an, ap};
            SRC_TIME:     r = 2'b00;
        endcase
        return r;
    endfunction

    wire [1:0] startLv = pick(startCfg_q, termSync_q, termPrev_q, counterOut, cntPrev_q, aceQual_q, acePrev_q);
    wire [1:0] refLv   = pick(refCfg_q,   termSync_q, termPrev_q, counterOut, cntPrev_q, aceQual_q, acePrev_q);
    wire [1:0] pauseLv = pick(pauseCfg_q, termSync_q, termPrev_q, counterOut, cntPrev_q, aceQual_q, acePrev_q);

    // analog start always rising; digital honours polarity (1 = falling)
    wire startEdgeDig = startCfg_q.polarity ? (!startLv[1] && startLv[0])
                                            : (startLv[1] && !startLv[0]);

    wire startEdgeAna = startLv[1] && !startLv[0];

    wire startTime    = (timeRef == tStart_q);
    wire startHw      = !startCfg_q.enable ? 1'b0 :
                        (startCfg_q.kind == SRC_ANALOG) ? startEdgeAna :
                        (startCfg_q.kind == SRC_TIME)   ? startTime : startEdgeDig;

    wire refEdge      = refCfg_q.polarity ? (!refLv[1] && refLv[0])
                                          : (refLv[1] && !refLv[0]);

    // level-only pause; polarity 1 = active low
    wire pauseActive  = pauseCfg_q.enable && (pauseLv[1] ^ pauseCfg_q.polarity);

    // bus handshake: both write channels taken together, answer one cycle later
    wire wrTake  = awvalid && wvalid && !bvalid;
    wire rdTake  = arvalid && !rvalid;

    wire cmdWr   = wrTake && awaddr == `ATC_OFF_CMD;
    wire swStart = cmdWr && wdata[`ATC_CMD_START];
    wire swStop  = cmdWr && wdata[`ATC_CMD_STOP];
    wire swSync  = cmdWr && wdata[`ATC_CMD_SYNC];

    wire wrKnown = awaddr <= `ATC_OFF_TSYNC;

    wire [31:0] postCnt = count_q - pretrig_q;
    wire        contMode = ctrl_q[`ATC_CTRL_CONT];
    wire        refMode  = ctrl_q[`ATC_CTRL_REFEN] && !contMode;
    wire        running  = state_q == ST_PRE || state_q == ST_ARMED || state_q == ST_POST || state_q == ST_RUN;
    wire        divTick  = divCnt_q >= period_q;
    wire        sampleTick = running && divTick && !pauseActive;
    wire        kick     = startCfg_q.enable ? startHw : swStart;
    wire        stopNow  = state_q == ST_RUN && ((contMode && swStop) ||
                           (!contMode && sampleTick && sampCnt_q + 32'h1 >= count_q));
    wire        preDone  = sampleTick && sampCnt_q + 32'h1 >= pretrig_q;
    wire        postDone = sampleTick && phaseCnt_q + 32'h1 >= postCnt;

    // acquisition sequencer
    atc_state_t state_d;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:  if (kick) state_d = (delay_q != 32'h0) ? ST_DELAY : (refMode ? ST_PRE : ST_RUN);
            ST_DELAY: if (phaseCnt_q + 32'h1 >= delay_q) state_d = refMode ? ST_PRE : ST_RUN;
            ST_PRE:   if (preDone) state_d = ST_ARMED;
            ST_ARMED: if (refEdge && refCfg_q.enable) state_d = ST_POST;
            ST_POST:  if (postDone) state_d = ST_IDLE;
            ST_RUN:   if (stopNow) state_d = ST_IDLE;
        endcase
        if (swStop && state_q != ST_IDLE)
            state_d = ST_IDLE;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_q    <= ST_IDLE;
            sampCnt_q  <= 32'h0;
            phaseCnt_q <= 32'h0;
            divCnt_q   <= 32'h0;
            wrPtr_q    <= '0;
            wrapped_q  <= 1'b0;
            done_q     <= 1'b0;
            refSeen_q  <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            divCnt_q <= (!running || divTick) ? 32'h0 : divCnt_q + 32'h1;
            if (state_q == ST_IDLE && kick)
            begin
                sampCnt_q  <= 32'h0;
                phaseCnt_q <= 32'h0;
                wrPtr_q    <= '0;
                wrapped_q  <= 1'b0;
                done_q     <= 1'b0;
                refSeen_q  <= 1'b0;
            end
            else if (state_q == ST_DELAY)
                phaseCnt_q <= (state_d != ST_DELAY) ? 32'h0 : phaseCnt_q + 32'h1;
            else
            begin
                if (sampleTick)
                begin
                    sampCnt_q <= sampCnt_q + 32'h1;
                    wrPtr_q   <= (wrPtr_q == AW'(BUF_DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
                    if (wrPtr_q == AW'(BUF_DEPTH - 1))
                        wrapped_q <= 1'b1;
                    if (state_q == ST_POST)
                        phaseCnt_q <= phaseCnt_q + 32'h1;
                end
                if (state_q == ST_ARMED && state_d == ST_POST)
                begin
                    refSeen_q  <= 1'b1;
                    phaseCnt_q <= 32'h0;
                end
                if (running && state_d == ST_IDLE)
                    done_q <= 1'b1;
            end
        end
    end

    // outputs from flip-flops: trigger pulses, sample clock, sync pulse, routing
    wire startFire = state_q == ST_IDLE && kick;

    wire refFire   = state_q == ST_ARMED && state_d == ST_POST;
    wire syncTime  = ctrl_q[`ATC_CTRL_SYNCEN] && ctrl_q[`ATC_CTRL_SYNCSHR] && timeRef == tSync_q && !tSyncFired_q;

    // a sync is issued on software command; when enabled and unshared, also at every start, even if commanded earlier
    wire syncSoft  = swSync || (ctrl_q[`ATC_CTRL_SYNCEN] && !ctrl_q[`ATC_CTRL_SYNCSHR] && startFire);
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            events       <= '0;
            syncCnt_q    <= '0;
            tSyncFired_q <= 1'b0;
            sampleAddr   <= '0;
            acqActive    <= 1'b0;
            programmable_function_terminal_out <= '0;
        end
        else
        begin
            events.startPulse  <= startFire;
            events.refPulse    <= refFire;
            events.sampleClock <= sampleTick;
            if (syncTime || syncSoft)
                syncCnt_q <= `ATC_SYNC_CYC_W'(`ATC_SYNC_CYC);
            else if (syncCnt_q != '0)
                syncCnt_q <= syncCnt_q - 1'b1;
            events.syncPulse   <= (syncTime || syncSoft || syncCnt_q > `ATC_SYNC_CYC_W'(1));
            if (syncTime)
                tSyncFired_q <= 1'b1;
            else if (timeRef != tSync_q)
                tSyncFired_q <= 1'b0;
            sampleAddr <= wrPtr_q;
            acqActive  <= running;
            programmable_function_terminal_out <= ({NUM_TERM{startFire}} & routeStart_q)
                                                | ({NUM_TERM{refFire}} & routeRef_q);
        end
    end

    // register writes
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl_q       <= 4'h0;
            startCfg_q   <= '0;
            refCfg_q     <= '0;
            pauseCfg_q   <= '0;
            count_q      <= 32'h0000_0400;
            pretrig_q    <= 32'h0;
            delay_q      <= 32'h0;
            period_q     <= `ATC_DEF_PERIOD;
            tStart_q     <= 32'h0;
            tSync_q      <= 32'h0;
            routeStart_q <= '0;
            routeRef_q   <= '0;
        end
        else if (wrTake)
        begin
            unique case (awaddr)
                `ATC_OFF_CTRL:    ctrl_q <= wdata[3:0];
                `ATC_OFF_START:   {routeStart_q, startCfg_q} <= {wdata[16 +: NUM_TERM], wdata[9:8], wdata[5:0]};
                `ATC_OFF_REF:     {routeRef_q, refCfg_q} <= {wdata[16 +: NUM_TERM], wdata[9:8], wdata[5:0]};
                `ATC_OFF_PAUSE:   pauseCfg_q <= {wdata[9:8], wdata[5:0]};
                `ATC_OFF_COUNT:   count_q    <= wdata;
                `ATC_OFF_PRETRIG: pretrig_q  <= wdata;
                `ATC_OFF_DELAY:   delay_q    <= wdata;
                `ATC_OFF_PERIOD:  period_q   <= wdata;
                `ATC_OFF_TSTART:  tStart_q   <= wdata;
                `ATC_OFF_TSYNC:   tSync_q    <= wdata;
                default:          ;
            endcase
        end
    end

    // read mux
    function automatic logic [31:0] cfgWord(input atc_trig_cfg_t c, input logic [NUM_TERM-1:0] r);
        logic [31:0] w;
        w = 32'h0;
        w[5:0] = {c.kind, c.source};
        w[`ATC_TRIG_POL] = c.polarity;
        w[`ATC_TRIG_EN]  = c.enable;
        w[16 +: NUM_TERM] = r;
        return w;
    endfunction

    wire        rdKnown = araddr <= `ATC_OFF_TIME;

    wire [31:0] statusWord = {24'h0, 4'(state_q), wrapped_q, refSeen_q, done_q, running};

    wire [31:0] rdWord =
        araddr == `ATC_OFF_CTRL    ? {28'h0, ctrl_q} :
        araddr == `ATC_OFF_START   ? cfgWord(startCfg_q, routeStart_q) :
        araddr == `ATC_OFF_REF     ? cfgWord(refCfg_q, routeRef_q) :
        araddr == `ATC_OFF_PAUSE   ? cfgWord(pauseCfg_q, '0) :
        araddr == `ATC_OFF_COUNT   ? count_q :
        araddr == `ATC_OFF_PRETRIG ? pretrig_q :
        araddr == `ATC_OFF_DELAY   ? delay_q :
        araddr == `ATC_OFF_PERIOD  ? period_q :
        araddr == `ATC_OFF_TSTART  ? tStart_q :
        araddr == `ATC_OFF_TSYNC   ? tSync_q :
        araddr == `ATC_OFF_STATUS  ? statusWord :
        araddr == `ATC_OFF_SAMPLES ? sampCnt_q :
        araddr == `ATC_OFF_WRPTR   ? 32'(wrPtr_q) :
        araddr == `ATC_OFF_TIME    ? timeRef : 32'h0;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= `ATC_RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `ATC_RESP_OKAY;
        end
        else
        begin
            awready <= wrTake;
            wready  <= wrTake;
            if (wrTake)
            begin
                bvalid <= 1'b1;
                bresp  <= (wrKnown && awaddr[1:0] == 2'b00) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
            end
            else if (bready)
                bvalid <= 1'b0;
            arready <= rdTake;
            if (rdTake)
            begin
                rvalid <= 1'b1;
                rdata  <= rdWord;
                rresp  <= (rdKnown && araddr[1:0] == 2'b00) ? `ATC_RESP_OKAY : `ATC_RESP_SLVERR;
            end
            else if (rready)
                rvalid <= 1'b0;
        end
    end
endmodule

// [sim/atc_trigger_ctrl_assertions.sv]
// checker for the trigger block: bus answers and event pulse shapes
// assumes it is bound to atc_trigger_ctrl and sees only its ports
`timescale 1ns/100ps
`include "atc_defines.svh"
module atc_trigger_ctrl_assertions
    import atc_pkg::*;
#(
    parameter int NUM_TERM = 8
)
(
    // clock and reset
    input wire logic                mclk,
    input wire logic                srst,
    // bus
    input wire logic [7:0]          awaddr,
    input wire logic                awvalid,
    input wire logic                awready,
    input wire logic                wvalid,
    input wire logic                wready,
    input wire logic [1:0]          bresp,
    input wire logic                bvalid,
    input wire logic [7:0]          araddr,
    input wire logic                arvalid,
    input wire logic                arready,
    input wire logic [31:0]         rdata,
    input wire logic [1:0]          rresp,
    input wire logic                rvalid,
    // events
    input wire logic [NUM_TERM-1:0] programmable_function_terminal_out,
    input wire atc_events_t         events,
    input wire logic                acqActive
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (srst);

    sequence wrTaken;
        awvalid && wvalid && !bvalid;
    endsequence
    sequence syncHeld;
        events.syncPulse [*5] ##1 !events.syncPulse;
    endsequence

    a_write_answer: assert property (wrTaken |=> awready && wready && bvalid)
        else $error("write not answered in one cycle");
    a_write_unmapped: assert property (wrTaken ##0 (awaddr > `ATC_OFF_TSYNC) |=> bresp == `ATC_RESP_SLVERR)
        else $error("unmapped write not refused");
    a_read_answer: assert property (arvalid && !rvalid |=> arready && rvalid)
        else $error("read not answered in one cycle");
    a_read_unmapped: assert property (arvalid && !rvalid && araddr > `ATC_OFF_TIME
        |=> rresp == `ATC_RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_start_single: assert property (events.startPulse |=> !events.startPulse)
        else $error("start pulse longer than one cycle");
    a_term_route: assert property (|programmable_function_terminal_out |-> events.startPulse || events.refPulse
        || $past(events.startPulse) || $past(events.refPulse))
        else $error("terminal pulse without a trigger");
    a_sync_width: assert property ($rose(events.syncPulse) |-> syncHeld)
        else $error("sync pulse not five cycles");
    a_sample_active: assert property (events.sampleClock |-> acqActive || $past(acqActive))
        else $error("sample outside acquisition");
endmodule

bind atc_trigger_ctrl atc_trigger_ctrl_assertions #(.NUM_TERM(NUM_TERM)) chk (.*);

// [sim/atc_module_model.sv]
// plug-in module model: tallies events, drives the comparison event
// assumes clear is raised before each acquisition
`timescale 1ns/100ps
module atc_module_model
    import atc_pkg::*;
(
    // clock and bench control
    input  wire logic        mclk,
    input  wire logic        clear,
    input  wire logic        eventReq,
    // block side
    input  wire atc_events_t events,
    output logic             analogCompEvent,
    // tallies
    output logic [15:0]      sampleCount,
    output logic [15:0]      postCount,
    output logic [15:0]      startCount,
    output logic [15:0]      refCount,
    output logic [15:0]      startGap,
    output logic [7:0]       syncCount
);
    always_ff @(posedge mclk)
    begin
        analogCompEvent <= eventReq;
        if (clear)
            {sampleCount, postCount, startCount, refCount, startGap, syncCount} <= '0;
        else
        begin
            sampleCount <= sampleCount + 16'(events.sampleClock);
            postCount <= postCount + 16'(events.sampleClock && refCount != 16'h0000);
            startCount <= startCount + 16'(events.startPulse);
            refCount <= refCount + 16'(events.refPulse);
            startGap <= startGap + 16'(startCount != 16'h0000 && sampleCount == 16'h0000);
            syncCount <= syncCount + 8'($rose(events.syncPulse));
        end
    end
endmodule

// [sim/atc_trigger_ctrl_tb_top.sv]
// self-checking bench for the trigger block
// assumes the design, its checker and the module model are compiled first
`timescale 1ns/100ps
`include "atc_defines.svh"
module atc_trigger_ctrl_tb_top
    import atc_pkg::*;
;
    logic        mclk = 1'b0, srst = 1'b1, clear = 1'b1, eventReq = 1'b0, wrapSeen = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, termIn = 8'h00, termOut, routeSeen = 8'h00;
    logic [31:0] wdata = 32'h0, timeRef = 32'h0, rdata, cnt, t0, startAt, snap;
    logic [3:0]  counterOut = 4'hF, sampleAddr, lastAddr;
    logic        awready, wready, bvalid, arready, rvalid, acqActive, analogCompEvent;
    logic [1:0]  bresp, rresp;
    logic [15:0] sampleCount, postCount, startCount, refCount, startGap;
    logic [7:0]  syncCount;
    logic [33:0] bq[$], rq[$];
    atc_events_t events;
    int          fail_count = 0, checked = 0, seed = 72381;

    atc_trigger_ctrl #(.BUF_DEPTH(16)) uut (.*, .wstrb(4'hF), .bready(1'b1), .rready(1'b1),
        .programmable_function_terminal_in(termIn), .programmable_function_terminal_out(termOut));
    atc_module_model model (.*);

    always #10 mclk = ~mclk;

    // result watcher: bus answers against queued notes, terminal routes, pointer wrap
    always @(posedge mclk)
    begin
        timeRef <= srst ? 32'h0 : timeRef + 32'h1;
        if (bvalid === 1'b1 && bq.size() > 0)
            chk({bresp, 32'h0}, bq.pop_front(), "bresp");
        if (rvalid === 1'b1 && rq.size() > 0)
            chk({rresp, rdata}, rq.pop_front(), "rdata");
        routeSeen <= clear ? 8'h00 : routeSeen | termOut;
        wrapSeen <= !clear && (wrapSeen || (sampleAddr == 4'h0 && lastAddr == 4'hF));
        lastAddr <= sampleAddr;
        if (events.startPulse === 1'b1)
            startAt <= timeRef;
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic lost;
        fail_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        final_report;
    endtask
    task automatic bus(input logic isWr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        if (isWr)
        begin
            bq.push_back({r, 32'h0});
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
        end
        else
        begin
            rq.push_back({r, d});
            araddr <= a;
            arvalid <= 1'b1;
        end
        for (n = 0; n < 20 && awready !== 1'b1 && arready !== 1'b1; n++)
            @(posedge mclk);
        if (n == 20)
            lost;
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        arvalid <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, `ATC_RESP_OKAY);
    endtask
    task automatic clearAll;
        clear <= 1'b1;
        @(posedge mclk);
        clear <= 1'b0;
    endtask
    // k: 0 acquisition over, 1 start seen, 2 reference seen
    task automatic waitFor(input int k, input int lim);
        int n;
        for (n = 0; n < lim; n++)
        begin
            @(posedge mclk);
            if (k == 0 ? (acqActive === 1'b0 && sampleCount != 0) : (k == 1 ? startCount != 0 : refCount != 0))
                break;
        end
        if (n == lim)
            lost;
    endtask

    initial
    begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        clear <= 1'b0;
        @(posedge mclk);
        bus(1'b0, `ATC_OFF_COUNT, 32'h0000_0400, `ATC_RESP_OKAY);
        bus(1'b0, `ATC_OFF_PERIOD, `ATC_DEF_PERIOD, `ATC_RESP_OKAY);
        bus(1'b0, 8'h3C, 32'h0, `ATC_RESP_SLVERR);
        bus(1'b1, `ATC_OFF_STATUS, 32'h1, `ATC_RESP_SLVERR);
        cnt = 32'd2 + ($unsigned($random(seed)) % 32'd8);
        wr(`ATC_OFF_PERIOD, 32'h3);
        wr(`ATC_OFF_DELAY, 32'd20);
        wr(`ATC_OFF_CTRL, 32'h4);
        wr(`ATC_OFF_COUNT, cnt);
        clearAll;
        wr(`ATC_OFF_CMD, 32'h1);
        waitFor(1, 50);
        waitFor(0, 500);
        repeat (20) @(posedge mclk);
        chk(sampleCount, cnt, "finite");
        chk(startGap >= 16'd20, 1, "delay");
        chk(syncCount, 1, "soft sync");
        $display("test 1 done");
        wr(`ATC_OFF_DELAY, 32'h0);
        wr(`ATC_OFF_START, 32'h0004_0303);
        clearAll;
        wr(`ATC_OFF_CMD, 32'h1);
        termIn <= 8'h08 | 8'($random(seed) & 32'hF7);
        repeat (20) @(posedge mclk);
        chk(startCount, 0, "rising");
        chk(sampleCount, 0, "early");
        termIn <= 8'($random(seed) & 32'hF7);
        waitFor(1, 8);
        waitFor(0, 500);
        chk(sampleCount, cnt, "count");
        chk(routeSeen, 8'h04, "route");
        chk(startCount, 1, "one start");
        $display("test 2 done");
        wr(`ATC_OFF_START, 32'h0);
        wr(`ATC_OFF_PAUSE, 32'h0000_0311);
        wr(`ATC_OFF_CTRL, 32'h1);
        clearAll;
        wr(`ATC_OFF_CMD, 32'h1);
        repeat (60) @(posedge mclk);
        counterOut <= 4'hD;
        repeat (4) @(posedge mclk);
        snap = 32'(sampleCount);
        repeat (60) @(posedge mclk);
        chk(sampleCount, snap, "paused");
        counterOut <= 4'hF;
        repeat (60) @(posedge mclk);
        chk(sampleCount > snap, 1, "resumed");
        chk(acqActive, 1, "running");
        wr(`ATC_OFF_CMD, 32'h2);
        repeat (4) @(posedge mclk);
        chk(acqActive, 0, "stopped");
        wr(`ATC_OFF_PAUSE, 32'h0);
        $display("test 3 done");
        wr(`ATC_OFF_CTRL, 32'h2);
        wr(`ATC_OFF_COUNT, 32'd8);
        wr(`ATC_OFF_PRETRIG, 32'd3);
        wr(`ATC_OFF_REF, 32'h0008_0220);
        clearAll;
        wr(`ATC_OFF_CMD, 32'h1);
        eventReq <= 1'b1;
        repeat (80) @(posedge mclk);
        chk(refCount, 0, "early ref");
        eventReq <= 1'b0;
        repeat (4) @(posedge mclk);
        eventReq <= 1'b1;
        waitFor(2, 10);
        waitFor(0, 500);
        chk(postCount, 5, "post");
        chk(routeSeen, 8'h08, "ref route");
        chk(wrapSeen, 1, "wrap");
        $display("test 4 done");
        wr(`ATC_OFF_CTRL, 32'hC);
        wr(`ATC_OFF_START, 32'h0000_0230);
        t0 = timeRef + 32'd100;
        wr(`ATC_OFF_TSTART, t0);
        wr(`ATC_OFF_TSYNC, t0 + 32'd10);
        clearAll;
        wr(`ATC_OFF_CMD, 32'h1);
        waitFor(1, 200);
        chk(startAt - t0 <= 32'd3, 1, "time start");
        waitFor(0, 500);
        chk(syncCount, 1, "timed sync");
        $display("test 5 done");
        final_report;
    end
endmodule
